// [frs_ctrl.sv]
// Host controller driving flash reset, status polling and unprotect pins
//
// Contract
// - Hold reset low at least 500 ns; device reads within 500 ns if idle.
// - Wait at least 50 ns after reset release before a read cycle.
// - Keep output enable high at least 20 ns between status reads.
// - Status reads may toggle output enable or chip enable; both bits advance.
// - Raise reset to unprotect voltage 4 us before the first write.
// - Keep unprotect voltage 4 us after ready/busy returns high.
`timescale 1ns/1ps
module frs_ctrl
  import frs_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic cmd_valid,
  input wire frs_op_type cmd_op,
  input wire logic [ADDR_W-1:0] cmd_addr,
  input wire logic [DATA_W-1:0] cmd_wdata,
  output logic cmd_ready,
  output logic rsp_valid,
  output logic [DATA_W-1:0] rsp_data,
  output logic rsp_suspend_toggled,
  output logic [ADDR_W-1:0] flash_addr,
  input wire logic [DATA_W-1:0] flash_dq_in,
  output logic [DATA_W-1:0] flash_dq_out,
  output logic flash_dq_oe,
  output logic flash_ce_n,
  output logic flash_oe_n,
  output logic flash_we_n,
  output logic flash_reset_n,
  output logic flash_reset_unprotect,
  output logic protect_accelerate_pin,
  input wire logic ready_busy_output
);
  frs_state_type state_reg;
  frs_state_type state_next;
  frs_op_type op_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic [DATA_W-1:0] wdata_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] rst_cnt_reg;
  logic [CNT_W-1:0] rdy_hi_cnt_reg;
  logic wake_reg;
  logic emb_reg;
  logic have_prev_reg;
  logic [DATA_W-1:0] prev_reg;
  logic [DATA_W-1:0] dq_sync;
  logic rdy_sync;
  logic [CNT_W-1:0] ready_need;
  logic leave;
  logic poll_stable;

  frs_sync #(.WIDTH(DATA_W)) u_dq_sync (
    .clock(clock),
    .resetn(resetn),
    .clk_en(clk_en),
    .async_in(flash_dq_in),
    .sync_out(dq_sync)
  );

  frs_sync #(.WIDTH(1)) u_rdy_sync (
    .clock(clock),
    .resetn(resetn),
    .clk_en(clk_en),
    .async_in(ready_busy_output),
    .sync_out(rdy_sync)
  );

  // Toggling stopped: two reads with equal operation toggle bit, any address
  assign poll_stable = have_prev_reg &&
    (dq_sync[OP_TOGGLE_BIT] == prev_reg[OP_TOGGLE_BIT]);
  assign ready_need = emb_reg ? READY_EMB_CYC : READY_CYC;
  assign leave = (state_next != state_reg);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (cmd_valid) begin
          state_next = flash_reset_n ? ST_DISPATCH : ST_RST_REC;
        end
      end
      ST_DISPATCH: begin
        case (op_reg)
          OP_READ, OP_POLL: state_next = ST_RD;
          OP_WRITE, OP_WRITE_LAST: state_next = ST_WR_LOW;
          OP_RESET, OP_STANDBY: state_next = ST_RST_LOW;
          OP_UNPROT_ON: state_next = ST_UNP_SETUP;
          OP_UNPROT_OFF: state_next = ST_UNP_HOLD;
          default: state_next = ST_DONE;
        endcase
      end
      ST_RST_LOW: begin
        if (op_reg == OP_STANDBY) begin
          if (cnt_reg >= RPD_CYC - CNT_ONE) begin
            state_next = ST_DONE;
          end
        end else if (cnt_reg >= RP_CYC - CNT_ONE) begin
          state_next = ST_RST_REC;
        end
      end
      ST_RST_REC: begin
        if (cnt_reg >= RH_CYC - CNT_ONE && rst_cnt_reg >= ready_need) begin
          state_next = wake_reg ? ST_DISPATCH : ST_DONE;
        end
      end
      ST_RD: begin
        if (cnt_reg >= RD_CYC - CNT_ONE) begin
          if (op_reg == OP_POLL && !poll_stable) begin
            state_next = ST_GAP;
          end else begin
            state_next = ST_DONE;
          end
        end
      end
      ST_GAP: begin
        if (cnt_reg >= OEPH_CYC - CNT_ONE) begin
          state_next = ST_RD;
        end
      end
      ST_WR_LOW: begin
        if (cnt_reg >= WP_CYC - CNT_ONE) begin
          state_next = ST_WR_HIGH;
        end
      end
      ST_WR_HIGH: begin
        if (cnt_reg >= WPH_CYC - CNT_ONE) begin
          state_next = (op_reg == OP_WRITE_LAST) ? ST_BUSY_WAIT : ST_DONE;
        end
      end
      ST_BUSY_WAIT: begin
        // Busy is only trusted after its settling time has passed
        if (cnt_reg >= BUSY_WAIT_CYC - CNT_ONE && rdy_sync) begin
          state_next = ST_DONE;
        end
      end
      ST_UNP_SETUP: begin
        if (cnt_reg >= RSP_CYC - CNT_ONE) begin
          state_next = ST_DONE;
        end
      end
      ST_UNP_HOLD: begin
        if (rdy_hi_cnt_reg >= RRB_CYC) begin
          state_next = ST_DONE;
        end
      end
      ST_DONE: state_next = ST_IDLE;
      default: state_next = ST_IDLE;
    endcase
  end

  // Sequencer state, step counter and latched command
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_reg <= ST_IDLE;
      cnt_reg <= CNT_ZERO;
      op_reg <= OP_READ;
      addr_reg <= '0;
      wdata_reg <= '0;
      wake_reg <= 1'b0;
      emb_reg <= 1'b0;
    end else if (clk_en) begin
      state_reg <= state_next;
      cnt_reg <= leave ? CNT_ZERO : (cnt_reg == CNT_MAX ? cnt_reg : cnt_reg + CNT_ONE);
      if (state_reg == ST_IDLE && cmd_valid) begin
        op_reg <= cmd_op;
        addr_reg <= cmd_addr;
        wdata_reg <= cmd_wdata;
        wake_reg <= !flash_reset_n;
      end else if (state_reg == ST_DISPATCH) begin
        wake_reg <= 1'b0;
      end
      if (state_next == ST_RST_LOW && state_reg != ST_RST_LOW) begin
        emb_reg <= !rdy_sync;
      end
    end
  end

  // Time since reset pin fell, and time ready/busy has been high
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rst_cnt_reg <= CNT_MAX;
      rdy_hi_cnt_reg <= CNT_ZERO;
    end else if (clk_en) begin
      if (state_next == ST_RST_LOW && state_reg != ST_RST_LOW) begin
        rst_cnt_reg <= CNT_ZERO;
      end else if (rst_cnt_reg != CNT_MAX) begin
        rst_cnt_reg <= rst_cnt_reg + CNT_ONE;
      end
      if (!rdy_sync) begin
        rdy_hi_cnt_reg <= CNT_ZERO;
      end else if (rdy_hi_cnt_reg != CNT_MAX) begin
        rdy_hi_cnt_reg <= rdy_hi_cnt_reg + CNT_ONE;
      end
    end
  end

  // Flash pins
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      flash_addr <= '0;
      flash_dq_out <= '0;
      flash_dq_oe <= 1'b0;
      flash_ce_n <= 1'b1;
      flash_oe_n <= 1'b1;
      flash_we_n <= 1'b1;
      flash_reset_n <= 1'b1;
      flash_reset_unprotect <= 1'b0;
      protect_accelerate_pin <= 1'b0;
    end else if (clk_en) begin
      if (state_reg == ST_DISPATCH) begin
        flash_addr <= addr_reg;
        flash_dq_out <= wdata_reg;
      end
      // Status reads are separated by output enable and chip enable both going high
      flash_oe_n <= (state_next != ST_RD);
      flash_ce_n <= !(state_next == ST_RD || state_next == ST_WR_LOW);
      flash_we_n <= (state_next != ST_WR_LOW);
      flash_dq_oe <= (state_next == ST_WR_LOW || state_next == ST_WR_HIGH);
      if (state_next == ST_RST_LOW) begin
        flash_reset_n <= 1'b0;
      end else if (state_next == ST_RST_REC) begin
        flash_reset_n <= 1'b1;
      end
      if (state_next == ST_UNP_SETUP) begin
        flash_reset_unprotect <= 1'b1;
      end else if (state_reg == ST_UNP_HOLD && state_next == ST_DONE) begin
        flash_reset_unprotect <= 1'b0;
      end
      if (state_reg == ST_DISPATCH && op_reg == OP_ACCEL_ON) begin
        protect_accelerate_pin <= 1'b1;
      end else if (state_reg == ST_DISPATCH && op_reg == OP_ACCEL_OFF) begin
        protect_accelerate_pin <= 1'b0;
      end
    end
  end

  // Status history and user response
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      have_prev_reg <= 1'b0;
      prev_reg <= '0;
      cmd_ready <= 1'b1;
      rsp_valid <= 1'b0;
      rsp_data <= '0;
      rsp_suspend_toggled <= 1'b0;
    end else if (clk_en) begin
      cmd_ready <= (state_next == ST_IDLE);
      rsp_valid <= (state_next == ST_DONE);
      if (state_reg == ST_DISPATCH) begin
        have_prev_reg <= 1'b0;
        rsp_suspend_toggled <= 1'b0;
      end else if (state_reg == ST_RD && leave) begin
        have_prev_reg <= 1'b1;
        prev_reg <= dq_sync;
        rsp_data <= dq_sync;
        rsp_suspend_toggled <= have_prev_reg &&
          (dq_sync[SUSPEND_TOGGLE_BIT] != prev_reg[SUSPEND_TOGGLE_BIT]);
      end
    end
  end

  // Helper counters watched by the checks below
  logic [CNT_W-1:0] hi_cnt_reg;
  logic [CNT_W-1:0] oe_hi_cnt_reg;
  logic [CNT_W-1:0] unp_cnt_reg;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      hi_cnt_reg <= CNT_MAX;
      oe_hi_cnt_reg <= CNT_MAX;
      unp_cnt_reg <= CNT_ZERO;
    end else if (clk_en) begin
      hi_cnt_reg <= !flash_reset_n ? CNT_ZERO :
        (hi_cnt_reg == CNT_MAX ? hi_cnt_reg : hi_cnt_reg + CNT_ONE);
      oe_hi_cnt_reg <= !flash_oe_n ? CNT_ZERO :
        (oe_hi_cnt_reg == CNT_MAX ? oe_hi_cnt_reg : oe_hi_cnt_reg + CNT_ONE);
      unp_cnt_reg <= !flash_reset_unprotect ? CNT_ZERO :
        (unp_cnt_reg == CNT_MAX ? unp_cnt_reg : unp_cnt_reg + CNT_ONE);
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  sequence s_we_rise;
    $rose(flash_we_n);
  endsequence

  a_reset_pulse_width: assert property ($rose(flash_reset_n) |->
    $past(rst_cnt_reg) >= RP_CYC - CNT_ONE)
    else $error("reset pulse shorter than minimum");
  a_read_after_reset: assert property ($fell(flash_oe_n) |-> hi_cnt_reg >= RH_CYC)
    else $error("read started too soon after reset release");
  a_embedded_ready: assert property ($fell(flash_oe_n) && emb_reg |->
    rst_cnt_reg >= READY_EMB_CYC)
    else $error("read before embedded reset recovery time");
  a_standby_entry: assert property ($rose(rsp_valid) && op_reg == OP_STANDBY |->
    !flash_reset_n && rst_cnt_reg >= RPD_CYC)
    else $error("standby reported before reset held long enough");
  a_status_gap: assert property ($fell(flash_oe_n) |-> oe_hi_cnt_reg >= OEPH_CYC)
    else $error("output enable high time between reads too short");
  a_unprotect_setup: assert property ($fell(flash_we_n) && flash_reset_unprotect |->
    unp_cnt_reg >= RSP_CYC)
    else $error("write too soon after unprotect voltage applied");
  a_unprotect_hold: assert property ($fell(flash_reset_unprotect) |->
    $past(rdy_hi_cnt_reg) >= RRB_CYC)
    else $error("unprotect voltage dropped too soon after ready");
  a_busy_wait_done: assert property ($rose(rsp_valid) && op_reg == OP_WRITE_LAST |->
    $past(rdy_sync) && $past(cnt_reg) >= BUSY_WAIT_CYC - CNT_ONE)
    else $error("final write answered before busy window and ready");
  a_poll_stable: assert property ($rose(rsp_valid) && op_reg == OP_POLL |->
    $past(poll_stable))
    else $error("poll finished while toggle bit still toggling");
  a_write_spacing: assert property (s_we_rise |-> flash_we_n [*5])
    else $error("write enable high time shorter than write cycle");
endmodule

// [frs_pkg.sv]
// Constants, timing counts and types for the flash reset and status controller
package frs_pkg;

  localparam int CLK_PERIOD_NS = 10;
  localparam int CNT_W = 12;
  localparam int ADDR_W = 22;
  localparam int DATA_W = 16;

  // Status bit positions on the data bus
  localparam int OP_TOGGLE_BIT = 6;
  localparam int SUSPEND_TOGGLE_BIT = 2;

  // Times as printed
  localparam int T_RP_NS = 500;
  localparam int T_READY_NS = 500;
  localparam int T_READY_EMB_US = 20;
  localparam int T_RH_NS = 50;
  localparam int T_RPD_US = 20;
  localparam int T_BUSY_NS = 90;
  localparam int T_OEPH_NS = 20;
  localparam int T_RSP_US = 4;
  localparam int T_RRB_US = 4;
  localparam int T_ACC_NS = 90;
  localparam int T_WP_NS = 35;
  localparam int T_WC_NS = 90;

  // Latency of the three-stage input synchroniser
  localparam int SYNC_LAT_CYC = 3;

  // Least times, rounded up to whole cycles
  localparam logic [CNT_W-1:0] RP_CYC = CNT_W'((T_RP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] READY_CYC =
    CNT_W'((T_READY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] READY_EMB_CYC =
    CNT_W'((T_READY_EMB_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] RH_CYC = CNT_W'((T_RH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] RPD_CYC =
    CNT_W'((T_RPD_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] BUSY_WAIT_CYC =
    CNT_W'((T_BUSY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_LAT_CYC);
  localparam logic [CNT_W-1:0] OEPH_CYC =
    CNT_W'((T_OEPH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] RSP_CYC =
    CNT_W'((T_RSP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] RRB_CYC =
    CNT_W'((T_RRB_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] RD_CYC =
    CNT_W'((T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_LAT_CYC + 2);
  localparam logic [CNT_W-1:0] WP_CYC = CNT_W'((T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] WPH_CYC =
    CNT_W'((T_WC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) - WP_CYC;

  localparam logic [CNT_W-1:0] CNT_MAX = 12'hFFF;
  localparam logic [CNT_W-1:0] CNT_ONE = 12'h001;
  localparam logic [CNT_W-1:0] CNT_ZERO = 12'h000;

  typedef enum logic [3:0] {
    OP_READ, OP_WRITE, OP_WRITE_LAST, OP_POLL, OP_RESET, OP_STANDBY,
    OP_UNPROT_ON, OP_UNPROT_OFF, OP_ACCEL_ON, OP_ACCEL_OFF
  } frs_op_type;

  typedef enum logic [3:0] {
    ST_IDLE, ST_DISPATCH, ST_RST_LOW, ST_RST_REC, ST_RD, ST_GAP,
    ST_WR_LOW, ST_WR_HIGH, ST_BUSY_WAIT, ST_UNP_SETUP, ST_UNP_HOLD, ST_DONE
  } frs_state_type;

endpackage

// [frs_sync.sv]
// Three-stage synchroniser that updates only when the last two stages agree
`timescale 1ns/1ps
module frs_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      sync_out <= '0;
    end else if (clk_en) begin
      s1_reg <= async_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) begin
        sync_out <= s3_reg;
      end
    end
  end
endmodule

// [frs_flash_model.sv]
// Behavioural flash device model answering the reset and status controller
`timescale 1ns/1ps
module frs_flash_model #(
  parameter logic [15:0] PROG_CMD = 16'h00A0,
  parameter logic [15:0] SUSP_CMD = 16'h00B0,
  parameter int PROG_NS = 11000,
  parameter int ACCEL_NS = 7000
) (
  input wire logic [21:0] addr,
  input wire logic [15:0] dq,
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic reset_n,
  input wire logic unprot,
  input wire logic accel,
  output logic [15:0] dq_out,
  output logic ready_busy,
  output logic standby,
  output int err_count
);
  logic [15:0] mem [int];
  logic [15:0] last = 16'h0000;
  logic [15:0] v;
  logic [15:0] pdata;
  logic [21:0] paddr;
  logic [6:0] ssec;
  logic armed = 1'b0;
  logic pend = 1'b0;
  logic susp = 1'b0;
  logic tog6 = 1'b0;
  logic tog2 = 1'b0;
  time busy_until = 0;
  time ready_at = 0;
  time rst_fall = 0;
  time rst_rise = 0;
  time rd_end = 0;
  time unp_rise = 0;
  time rb_rise = 0;
  wire rd = !ce_n && !oe_n && reset_n;
  wire wr = !ce_n && !we_n && reset_n;
  initial begin
    err_count = 0;
    dq_out = 16'hFFFF;
  end
  // Ticks off the controller's clock edges so sampling never races
  initial begin
    #2;
    forever begin
      if (ready_busy === 1'b0 && $time >= busy_until) rb_rise = $time;
      ready_busy = $time >= busy_until;
      standby = !reset_n && ($time - rst_fall >= 20000);
      #5;
    end
  end
  always @(posedge rd) begin
    if ($time - rst_rise < 50) err_count++;
    if ($time < busy_until && $time - rd_end < 20) err_count++;
    if (pend && $time >= busy_until) begin
      mem[int'(paddr)] = pdata;
      pend = 1'b0;
    end
    v = ~last;
    if ($time < busy_until) begin
      tog6 = ~tog6;
      v = 16'h0000;
      v[6] = tog6;
    end else if (susp && addr[21:15] == ssec) begin
      tog2 = ~tog2;
      v = 16'h0000;
      v[2] = tog2;
    end else if ($time >= ready_at) begin
      v = mem.exists(int'(addr)) ? mem[int'(addr)] : 16'hFFFF;
    end
    dq_out = ~last;
    #90;
    if (rd) begin
      dq_out = v;
      last = v;
    end
  end
  // A released bus shows the inverse of the last value
  always @(negedge rd) begin
    rd_end = $time;
    dq_out = ~last;
  end
  // Erase itself is not modelled; a suspend write marks the sector
  always @(negedge wr) begin
    if (reset_n === 1'b1) begin
      if (unprot && $time - unp_rise < 4000) err_count++;
      if (armed) begin
        paddr = addr;
        pdata = dq;
        pend = 1'b1;
        armed = 1'b0;
        busy_until = $time + (accel ? ACCEL_NS : PROG_NS);
      end else if (dq == SUSP_CMD) begin
        susp = 1'b1;
        ssec = addr[21:15];
      end else begin
        armed = dq == PROG_CMD;
      end
    end
  end
  always @(negedge reset_n) begin
    rst_fall = $time;
    ready_at = $time + (($time < busy_until) ? 20000 : 500);
    if ($time < busy_until) busy_until = $time + 20000;
    pend = 1'b0;
    armed = 1'b0;
  end
  always @(posedge reset_n) begin
    rst_rise = $time;
    if (rst_fall > 0 && $time - rst_fall < 500) err_count++;
  end
  always @(posedge unprot) unp_rise = $time;
  always @(negedge unprot) begin
    if (unp_rise > 0 && $time - rb_rise < 4000) err_count++;
  end
endmodule

// [test_flash_reset_status_timing.sv]
// Self-checking bench for the flash reset and status controller
`timescale 1ns/1ps
module test_flash_reset_status_timing
  import frs_pkg::*;
;
  localparam logic [15:0] PROG_CMD = 16'h00A0;
  localparam logic [15:0] SUSP_CMD = 16'h00B0;
  localparam int PROG_NS = 11000;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic cmd_valid = 1'b0;
  frs_op_type cmd_op = OP_READ;
  logic [ADDR_W-1:0] cmd_addr = '0;
  logic [DATA_W-1:0] cmd_wdata = '0;
  logic cmd_ready, rsp_valid, rsp_suspend_toggled, flash_dq_oe, flash_ce_n, flash_oe_n;
  logic flash_we_n, flash_reset_n, flash_reset_unprotect, protect_accelerate_pin;
  logic ready_busy_output, standby;
  logic [DATA_W-1:0] rsp_data, flash_dq_out, mdl_dq, dq_bus;
  logic [ADDR_W-1:0] flash_addr;
  int mdl_err;
  int fail_count = 0;
  int tests_run = 0;
  int cyc, low;
  time rb_t = 0;
  time unp_fall = 0;
  // Last rise of ready/busy and last drop of the unprotect voltage
  always @(posedge ready_busy_output) rb_t = $time;
  always @(negedge flash_reset_unprotect) unp_fall = $time;
  assign dq_bus = flash_dq_oe ? flash_dq_out : mdl_dq;
  frs_ctrl DUT (
    .clock, .resetn, .clk_en(1'b1), .cmd_valid, .cmd_op, .cmd_addr, .cmd_wdata, .cmd_ready,
    .rsp_valid, .rsp_data, .rsp_suspend_toggled, .flash_addr, .flash_dq_in(dq_bus),
    .flash_dq_out, .flash_dq_oe, .flash_ce_n, .flash_oe_n, .flash_we_n, .flash_reset_n,
    .flash_reset_unprotect, .protect_accelerate_pin, .ready_busy_output);
  frs_flash_model #(.PROG_CMD(PROG_CMD), .SUSP_CMD(SUSP_CMD), .PROG_NS(PROG_NS)) mdl (
    .addr(flash_addr), .dq(dq_bus), .ce_n(flash_ce_n), .oe_n(flash_oe_n), .we_n(flash_we_n),
    .reset_n(flash_reset_n), .unprot(flash_reset_unprotect), .accel(protect_accelerate_pin),
    .dq_out(mdl_dq), .ready_busy(ready_busy_output), .standby(standby), .err_count(mdl_err));
  initial begin
    forever #5 clock = ~clock;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR time=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Issues one command and counts cycles, and reset-low cycles, up to its response
  task automatic cmd(input frs_op_type op, input logic [21:0] a, input logic [15:0] d);
    @(posedge clock);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_addr <= a;
    cmd_wdata <= d;
    do @(posedge clock); while (cmd_ready !== 1'b1);
    cmd_valid <= 1'b0;
    cyc = 0;
    low = 0;
    while (rsp_valid !== 1'b1 && cyc < 5000) begin
      @(posedge clock);
      cyc++;
      if (flash_reset_n === 1'b0) low++;
    end
  endtask
  task automatic t_reset_idle();
    cmd(OP_RESET, '0, '0);
    check(low >= RP_CYC, 1'b1);
    cmd(OP_READ, 22'h000100, '0);
    check(rsp_data, 16'hFFFF);
    $display("done reset_idle");
  endtask
  task automatic t_program();
    logic [DATA_W-1:0] s1;
    cmd(OP_ACCEL_ON, '0, '0);
    check(protect_accelerate_pin, 1'b1);
    cmd(OP_WRITE, 22'h000200, PROG_CMD);
    cmd(OP_WRITE, 22'h000200, 16'h1234);
    check(ready_busy_output, 1'b0);
    cmd(OP_READ, 22'h3F0000, '0);
    s1 = rsp_data;
    check(s1 & 16'hFFBB, 16'h0000);
    cmd(OP_READ, 22'h000007, '0);
    check(s1[6] ^ rsp_data[6], 1'b1);
    cmd(OP_POLL, 22'h000200, '0);
    check(rsp_data, 16'h1234);
    cmd(OP_ACCEL_OFF, '0, '0);
    check(protect_accelerate_pin, 1'b0);
    $display("done program");
  endtask
  task automatic t_suspend();
    cmd(OP_WRITE, 22'h200000, SUSP_CMD);
    cmd(OP_POLL, 22'h200010, '0);
    check(rsp_suspend_toggled, 1'b1);
    cmd(OP_POLL, 22'h000010, '0);
    check(rsp_suspend_toggled, 1'b0);
    $display("done suspend");
  endtask
  task automatic t_reset_busy();
    cmd(OP_WRITE, 22'h000300, PROG_CMD);
    cmd(OP_WRITE, 22'h000300, 16'h5A5A);
    repeat (5) @(posedge clock);
    cmd(OP_RESET, '0, '0);
    check(cyc >= READY_EMB_CYC, 1'b1);
    cmd(OP_READ, 22'h000300, '0);
    check(rsp_data, 16'hFFFF);
    $display("done reset_busy");
  endtask
  task automatic t_standby();
    cmd(OP_STANDBY, '0, '0);
    repeat (2) @(posedge clock);
    check(standby, 1'b1);
    check(flash_reset_n, 1'b0);
    cmd(OP_READ, 22'h000200, '0);
    check(rsp_data, 16'h1234);
    $display("done standby");
  endtask
  task automatic t_unprotect();
    cmd(OP_UNPROT_ON, '0, '0);
    check(flash_reset_unprotect, 1'b1);
    cmd(OP_WRITE, 22'h000400, PROG_CMD);
    cmd(OP_WRITE_LAST, 22'h000400, 16'hC3C3);
    check(cyc >= PROG_NS / CLK_PERIOD_NS, 1'b1);
    cmd(OP_UNPROT_OFF, '0, '0);
    check(unp_fall - rb_t >= RRB_CYC * CLK_PERIOD_NS, 1'b1);
    check(flash_reset_unprotect, 1'b0);
    cmd(OP_READ, 22'h000400, '0);
    check(rsp_data, 16'hC3C3);
    $display("done unprotect");
  endtask
  task automatic final_report();
    $display("checks=%0d mismatches=%0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge clock);
    fail_count++;
    final_report();
  end
  initial begin
    repeat (16) @(posedge clock);
    resetn <= 1'b1;
    t_reset_idle();
    t_program();
    t_suspend();
    t_reset_busy();
    t_standby();
    t_unprotect();
    check(mdl_err, 32'h0);
    final_report();
  end
endmodule
